// >>> shared/dapmc_pkg.sv
package dapmc_pkg;

  // Tri-level pad comparator codes for the multi-function pins.
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_MID  = 2'h2;

  // Converter word width and channel count.
  localparam int SAMPLE_W  = 8;
  localparam int CHAN_NUM  = 2;

  // Calibration request qualification, in input clock cycles.
  localparam int CAL_MIN_CYCLES = 80;
  localparam int CAL_CNT_W      = 8;

  // Serial configuration frame length in bits.
  localparam int SER_FRAME_BITS = 16;

  // Register byte offsets.
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_SERIAL = 4'h8;

  // Config register field positions (extended control mode settings).
  localparam int CFG_RANGE_BIT = 0;
  localparam int CFG_AMP_BIT   = 1;
  localparam int CFG_EDGE_BIT  = 2;
  localparam int CFG_DDR_BIT   = 3;
  localparam int CFG_W         = 4;
  localparam logic [3:0] CFG_RESET = 4'h2;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded operating mode.
  typedef struct packed {
    logic extended;
    logic rangeHigh;
    logic ampNormal;
    logic edgeRise;
    logic ddr;
    logic interleave;
  } dapmc_mode_s;

endpackage

// >>> rtl/dapmc_control.sv
`timescale 1ns/1ps
// Operation
// - Calibration starts only after a qualified low then qualified high interval.
// - Full power-down high powers down both channels and their logic.
// - Second-channel power-down high stops only the Q channel.
// - Sync pulse resets the output data clock for multi-device alignment.
// - Normal mode: range pin low gives 650 mV, high gives 870 mV.
// - Range pin floating or mid-supply selects extended control mode.
// - Extended mode: amplitude pin becomes the serial shift clock.
// - Normal mode: amplitude pin high normal swing, low reduced swing.
// - Normal mode: edge pin picks output clock edge where data changes.
// - Normal mode: edge pin floating selects double data rate output clocking.
// - Extended mode: edge pin becomes serial data, sampled on shift clock.
// - Each channel demultiplexes 1:2 onto two half-rate buses.
// - Each result is an 8-bit offset binary word.
// - Interleave mode lets both channels act as one double-rate converter.
// - Range pin floating: delay pin is serial chip select, delay short.
// - Analog input is sampled on the falling edge of the input clock.
module dapmc_control #(
  parameter int CAL_CYCLES = dapmc_pkg::CAL_MIN_CYCLES
) (
  // Clock, reset, enable.
  input  wire logic                          clock,
  input  wire logic                          srst,
  input  wire logic                          ce,
  // Control pins (asynchronous to clock).
  input  wire logic                          calRequestPin,
  input  wire logic                          fullPowerDownPin,
  input  wire logic                          secondChannelPowerDownPin,
  input  wire logic                          outputClockSyncPulsePin,
  input  wire logic [1:0]                    rangeSelectExtendedEnable,
  input  wire logic [1:0]                    amplitudeSelectSerialClock,
  input  wire logic [1:0]                    edgeSelectSerialData,
  input  wire logic [1:0]                    calDelayChipSelect,
  // Converter core results, two's complement, same clock.
  input  wire logic [7:0]                    coreSampleI,
  input  wire logic [7:0]                    coreSampleQ,
  // Output buses and clock.
  output logic [1:0][7:0]                    busA,
  output logic [1:0][7:0]                    busB,
  output logic                               outputDataClock,
  // Core controls.
  output logic                               calStart,
  output logic                               powerDownI,
  output logic                               powerDownQ,
  output logic                               rangeHigh,
  output logic                               ampNormal,
  output logic                               calDelayLong,
  output dapmc_pkg::dapmc_mode_s             modeOut,
  // AXI4-Lite slave.
  input  wire logic [3:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [3:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);

  typedef enum logic [1:0] {CAL_IDLE, CAL_LOW, CAL_HIGH, CAL_DONE} dapmc_cal_e;

  localparam int PIN_W = 12;
  localparam int CAL_CNT_W_L = dapmc_pkg::CAL_CNT_W;
  localparam logic [CAL_CNT_W_L-1:0] CAL_TARGET = CAL_CNT_W_L'(CAL_CYCLES);

  // All pins pass two flip-flops; only the second stage is read.
  logic [PIN_W-1:0] pinSync1_ff;
  logic [PIN_W-1:0] pinSync2_ff;
  wire  [PIN_W-1:0] pinRaw = {calRequestPin, fullPowerDownPin, secondChannelPowerDownPin,
                              outputClockSyncPulsePin, rangeSelectExtendedEnable,
                              amplitudeSelectSerialClock, edgeSelectSerialData,
                              calDelayChipSelect};
  always_ff @(posedge clock) begin
    if (srst) begin
      pinSync1_ff <= '0;
      pinSync2_ff <= '0;
    end else if (ce) begin
      pinSync1_ff <= pinRaw;
      pinSync2_ff <= pinSync1_ff;
    end
  end

  wire       calReqS   = pinSync2_ff[11];
  wire       fullPdS   = pinSync2_ff[10];
  wire       secPdS    = pinSync2_ff[9];
  wire       syncPlsS  = pinSync2_ff[8];
  wire [1:0] rangeLvl  = pinSync2_ff[7:6];
  wire [1:0] ampLvl    = pinSync2_ff[5:4];
  wire [1:0] edgeLvl   = pinSync2_ff[3:2];
  wire [1:0] delayLvl  = pinSync2_ff[1:0];

  // Three-level decode; mid comes from a floating or half-supply pin.
  wire extMode  = (rangeLvl == dapmc_pkg::LVL_MID);
  wire edgeMid  = (edgeLvl == dapmc_pkg::LVL_MID);
  wire delayMid = (delayLvl == dapmc_pkg::LVL_MID);

  logic [dapmc_pkg::CFG_W-1:0] config_ff;

  // Normal mode reads the pins; extended mode reads the config register.
  wire nxtRange = extMode ? config_ff[dapmc_pkg::CFG_RANGE_BIT]
                          : (rangeLvl == dapmc_pkg::LVL_HIGH);
  wire nxtAmp   = extMode ? config_ff[dapmc_pkg::CFG_AMP_BIT]
                          : (ampLvl == dapmc_pkg::LVL_HIGH);
  wire nxtEdge  = extMode ? config_ff[dapmc_pkg::CFG_EDGE_BIT]
                          : (edgeLvl == dapmc_pkg::LVL_HIGH);
  wire nxtDdr   = extMode ? config_ff[dapmc_pkg::CFG_DDR_BIT] : edgeMid;
  // A long delay is only possible outside extended mode.
  wire nxtDelayLong = ~extMode & (delayLvl == dapmc_pkg::LVL_HIGH);
  wire nxtInterleave = delayMid;

  // Mode and power flags, registered so every output comes from a flop.
  dapmc_pkg::dapmc_mode_s mode_ff;
  logic pdI_ff;
  logic pdQ_ff;
  logic delayLong_ff;
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_ff      <= '0;
      pdI_ff       <= 1'b0;
      pdQ_ff       <= 1'b0;
      delayLong_ff <= 1'b0;
    end else if (ce) begin
      mode_ff      <= '{extMode, nxtRange, nxtAmp, nxtEdge, nxtDdr, nxtInterleave};
      pdI_ff       <= fullPdS;
      pdQ_ff       <= fullPdS | secPdS;
      delayLong_ff <= nxtDelayLong;
    end
  end

  // Calibration request qualifier: low run then high run, each CAL_CYCLES long.
  dapmc_cal_e              calState_ff;
  dapmc_cal_e              nxtCalState;
  logic [CAL_CNT_W_L-1:0]  calCnt_ff;
  logic [CAL_CNT_W_L-1:0]  nxtCalCnt;
  logic                    calStart_ff;
  logic                    nxtCalStart;
  wire                     calCntFull = (calCnt_ff >= CAL_TARGET);
  wire [CAL_CNT_W_L-1:0]   calCntInc  = calCntFull ? calCnt_ff : calCnt_ff + 1'b1;
  always_comb begin
    nxtCalState = calState_ff;
    nxtCalCnt   = calCntInc;
    nxtCalStart = 1'b0;
    case (calState_ff)
      CAL_IDLE, CAL_DONE: begin
        nxtCalCnt = CAL_CNT_W_L'(1);
        if (!calReqS) begin
          nxtCalState = CAL_LOW;
        end
      end
      CAL_LOW: begin
        if (calReqS) begin
          nxtCalCnt   = CAL_CNT_W_L'(1);
          nxtCalState = calCntFull ? CAL_HIGH : CAL_IDLE;
        end
      end
      CAL_HIGH: begin
        if (!calReqS) begin
          nxtCalCnt   = CAL_CNT_W_L'(1);
          nxtCalState = CAL_LOW;
        end else if (calCntInc == CAL_TARGET) begin
          nxtCalStart = 1'b1;
          nxtCalState = CAL_DONE;
        end
      end
      default: begin
        nxtCalState = CAL_IDLE;
      end
    endcase
  end

  // Full power-down resets the qualifier to CAL_IDLE, since the core cannot calibrate then.
  always_ff @(posedge clock) begin
    if (srst || (ce && pdI_ff)) begin
      calState_ff <= CAL_IDLE;
      calCnt_ff   <= '0;
      calStart_ff <= 1'b0;
    end else if (ce) begin
      calState_ff <= nxtCalState;
      calCnt_ff   <= nxtCalCnt;
      calStart_ff <= nxtCalStart;
    end
  end

  // Serial port: shift clock and data share the amplitude and edge pins.
  // The shift clock is oversampled, so it must stay well below clock/4.
  logic                                 serClkPrev_ff;
  logic [dapmc_pkg::SER_FRAME_BITS-1:0] serShift_ff;
  logic [4:0]                           serBits_ff;
  logic [dapmc_pkg::SER_FRAME_BITS-1:0] serWord_ff;
  wire serClk    = (ampLvl == dapmc_pkg::LVL_HIGH);
  wire serData   = (edgeLvl == dapmc_pkg::LVL_HIGH);
  wire serSelect = extMode & (delayLvl == dapmc_pkg::LVL_LOW);
  wire serRise   = serClk & ~serClkPrev_ff & serSelect;
  wire frameDone = serSelect & serRise &
                   (serBits_ff == 5'(dapmc_pkg::SER_FRAME_BITS - 1));
  wire [dapmc_pkg::SER_FRAME_BITS-1:0] serNext =
      {serShift_ff[dapmc_pkg::SER_FRAME_BITS-2:0], serData};
  always_ff @(posedge clock) begin
    if (srst) begin
      serClkPrev_ff <= 1'b0;
      serShift_ff   <= '0;
      serBits_ff    <= '0;
      serWord_ff    <= '0;
    end else if (ce) begin
      serClkPrev_ff <= serClk;
      if (!serSelect || frameDone) begin
        serBits_ff <= '0;
      end else if (serRise) begin
        serBits_ff <= serBits_ff + 5'h01;
      end
      if (serRise) begin
        serShift_ff <= serNext;
      end
      if (frameDone) begin
        serWord_ff <= serNext;
      end
    end
  end

  // Output clock divider; the sync pulse rising edge restarts it.
  logic       syncPrev_ff;
  logic [1:0] div_ff;
  logic       outClk_ff;
  wire        syncRise = syncPlsS & ~syncPrev_ff;
  wire [1:0]  nxtDiv   = syncRise ? 2'h0 : div_ff + 2'h1;
  wire        nxtOutClk = mode_ff.ddr ? nxtDiv[1] : (nxtDiv[0] ^ ~mode_ff.edgeRise);
  always_ff @(posedge clock) begin
    if (srst) begin
      syncPrev_ff <= 1'b0;
      div_ff      <= '0;
      outClk_ff   <= 1'b0;
    end else if (ce) begin
      syncPrev_ff <= syncPlsS;
      div_ff      <= nxtDiv;
      outClk_ff   <= pdI_ff ? 1'b0 : nxtOutClk;
    end
  end

  // Falling-edge capture of the core result, where the input is sampled.
  logic [7:0] capNegI_ff;
  logic [7:0] capNegQ_ff;
  logic [7:0] capPosI_ff;
  always_ff @(negedge clock) begin
    if (srst) begin
      capNegI_ff <= '0;
      capNegQ_ff <= '0;
    end else if (ce) begin
      capNegI_ff <= coreSampleI;
      capNegQ_ff <= coreSampleQ;
    end
  end
  // Interleave fills the Q path from I on the opposite clock edge.
  always_ff @(posedge clock) begin
    if (srst) begin
      capPosI_ff <= '0;
    end else if (ce) begin
      capPosI_ff <= coreSampleI;
    end
  end

  // Pair phase of the 1:2 demultiplexer follows the divider.
  wire       pairLast = div_ff[0];
  wire [7:0] chanIn [dapmc_pkg::CHAN_NUM];
  wire       chanPd [dapmc_pkg::CHAN_NUM];
  assign chanIn[0] = capNegI_ff;
  assign chanIn[1] = mode_ff.interleave ? capPosI_ff : capNegQ_ff;
  assign chanPd[0] = pdI_ff;
  assign chanPd[1] = pdQ_ff;

  logic [1:0][7:0] busA_ff;
  logic [1:0][7:0] busB_ff;
  genvar ch;
  generate
    for (ch = 0; ch < dapmc_pkg::CHAN_NUM; ch++) begin : g_chan
      logic [7:0] holdA_ff;
      // Offset binary is two's complement with the sign bit inverted.
      wire  [7:0] offBin = {~chanIn[ch][7], chanIn[ch][6:0]};
      always_ff @(posedge clock) begin
        if (srst || (ce && chanPd[ch])) begin
          holdA_ff    <= '0;
          busA_ff[ch] <= '0;
          busB_ff[ch] <= '0;
        end else if (ce) begin
          if (!pairLast) begin
            holdA_ff <= offBin;
          end else begin
            busA_ff[ch] <= holdA_ff;
            busB_ff[ch] <= offBin;
          end
        end
      end
    end
  endgenerate

  // AXI4-Lite slave: address and data taken in either order.
  logic        awReady_ff;
  logic        wReady_ff;
  logic [3:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        bValid_ff;
  logic [1:0]  bResp_ff;
  logic        arReady_ff;
  logic        rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0]  rResp_ff;
  wire awTake  = s_axi_awvalid & awReady_ff;
  wire wTake   = s_axi_wvalid & wReady_ff;
  wire doWrite = ~awReady_ff & ~wReady_ff & ~bValid_ff;
  wire wrCfg   = doWrite & (awAddr_ff == dapmc_pkg::OFS_CONFIG) & wStrb_ff[0];
  wire wrHit   = (awAddr_ff == dapmc_pkg::OFS_CONFIG);
  wire arTake  = s_axi_arvalid & arReady_ff;
  wire rdCfg   = (s_axi_araddr == dapmc_pkg::OFS_CONFIG);
  wire rdStat  = (s_axi_araddr == dapmc_pkg::OFS_STATUS);
  wire rdSer   = (s_axi_araddr == dapmc_pkg::OFS_SERIAL);
  wire [31:0] statWord = {21'h000000, calState_ff, pdQ_ff, pdI_ff, delayLong_ff,
                          mode_ff.interleave, mode_ff.ddr, mode_ff.edgeRise,
                          mode_ff.ampNormal, mode_ff.rangeHigh, mode_ff.extended};
  wire [31:0] rdWord = rdCfg  ? {28'h0000000, config_ff} :
                       rdStat ? statWord :
                       rdSer  ? {16'h0000, serWord_ff} : 32'h00000000;

  // Write channel handshake and response.
  always_ff @(posedge clock) begin
    if (srst) begin
      awReady_ff <= 1'b1;
      wReady_ff  <= 1'b1;
      awAddr_ff  <= '0;
      wData_ff   <= '0;
      wStrb_ff   <= '0;
      bValid_ff  <= 1'b0;
      bResp_ff   <= dapmc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (awTake) begin
        awReady_ff <= 1'b0;
        awAddr_ff  <= s_axi_awaddr;
      end
      if (wTake) begin
        wReady_ff <= 1'b0;
        wData_ff  <= s_axi_wdata;
        wStrb_ff  <= s_axi_wstrb;
      end
      if (doWrite) begin
        bValid_ff <= 1'b1;
        bResp_ff  <= wrHit ? dapmc_pkg::RESP_OKAY : dapmc_pkg::RESP_SLVERR;
      end else if (bValid_ff && s_axi_bready) begin
        bValid_ff  <= 1'b0;
        awReady_ff <= 1'b1;
        wReady_ff  <= 1'b1;
      end
    end
  end

  // A finished serial frame loads the config; a bus write in the same cycle wins.
  always_ff @(posedge clock) begin
    if (srst) begin
      config_ff <= dapmc_pkg::CFG_RESET;
    end else if (ce) begin
      if (wrCfg) begin
        config_ff <= wData_ff[dapmc_pkg::CFG_W-1:0];
      end else if (frameDone) begin
        config_ff <= serNext[dapmc_pkg::CFG_W-1:0];
      end
    end
  end

  // Read channel: one-cycle answer after the address is taken.
  always_ff @(posedge clock) begin
    if (srst) begin
      arReady_ff <= 1'b1;
      rValid_ff  <= 1'b0;
      rData_ff   <= '0;
      rResp_ff   <= dapmc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arTake) begin
        arReady_ff <= 1'b0;
        rValid_ff  <= 1'b1;
        rData_ff   <= rdWord;
        rResp_ff   <= (rdCfg | rdStat | rdSer) ? dapmc_pkg::RESP_OKAY : dapmc_pkg::RESP_SLVERR;
      end else if (rValid_ff && s_axi_rready) begin
        rValid_ff  <= 1'b0;
        arReady_ff <= 1'b1;
      end
    end
  end

  // Output drive.
  assign busA            = busA_ff;
  assign busB            = busB_ff;
  assign outputDataClock = outClk_ff;
  assign calStart        = calStart_ff;
  assign powerDownI      = pdI_ff;
  assign powerDownQ      = pdQ_ff;
  assign rangeHigh       = mode_ff.rangeHigh;
  assign ampNormal       = mode_ff.ampNormal;
  assign calDelayLong    = delayLong_ff;
  assign modeOut         = mode_ff;
  assign s_axi_awready   = awReady_ff;
  assign s_axi_wready    = wReady_ff;
  assign s_axi_bvalid    = bValid_ff;
  assign s_axi_bresp     = bResp_ff;
  assign s_axi_arready   = arReady_ff;
  assign s_axi_rvalid    = rValid_ff;
  assign s_axi_rdata     = rData_ff;
  assign s_axi_rresp     = rResp_ff;

  // Helper: length of the current high run on the synchronised request.
  logic [CAL_CNT_W_L-1:0] hiRun_ff;
  always_ff @(posedge clock) begin
    if (srst) begin
      hiRun_ff <= '0;
    end else if (ce) begin
      if (!calReqS) begin
        hiRun_ff <= '0;
      end else if (hiRun_ff != '1) begin
        hiRun_ff <= hiRun_ff + 1'b1;
      end
    end
  end

  a_cal_high_run: assert property (@(posedge clock) disable iff (srst)
    $rose(calStart_ff) |-> hiRun_ff >= CAL_TARGET - 1'b1)
    else $error("Calibration started before a full high interval.");
  a_cal_pulse_one: assert property (@(posedge clock) disable iff (srst)
    ce && calStart_ff |=> !calStart_ff)
    else $error("Calibration start lasted more than one cycle.");
  a_full_pd_buses: assert property (@(posedge clock) disable iff (srst)
    ce && pdI_ff |=> busA_ff == '0 && busB_ff == '0 && !outClk_ff)
    else $error("Outputs active during full power-down.");
  a_q_pd_only: assert property (@(posedge clock) disable iff (srst)
    ce && secPdS && !fullPdS |=> pdQ_ff && !pdI_ff)
    else $error("Second-channel power-down affected the first channel.");
  a_sync_restart: assert property (@(posedge clock) disable iff (srst)
    ce && syncRise |=> div_ff == 2'h0)
    else $error("Sync pulse did not restart the output clock divider.");
  a_range_normal: assert property (@(posedge clock) disable iff (srst)
    ce && !extMode |=> mode_ff.rangeHigh == ($past(rangeLvl) == dapmc_pkg::LVL_HIGH))
    else $error("Range select not taken from the pin in normal mode.");
  a_ext_mode: assert property (@(posedge clock) disable iff (srst)
    ce && extMode |=> mode_ff.extended &&
    mode_ff.rangeHigh == $past(config_ff[dapmc_pkg::CFG_RANGE_BIT]))
    else $error("Floating range pin did not select extended mode.");
  a_ddr_float: assert property (@(posedge clock) disable iff (srst)
    ce && !extMode && edgeMid |=> mode_ff.ddr)
    else $error("Floating edge pin did not enable double data rate.");
  a_delay_short: assert property (@(posedge clock) disable iff (srst)
    mode_ff.extended |-> !calDelayLong)
    else $error("Long calibration delay seen in extended mode.");
  a_demux_pair: assert property (@(posedge clock) disable iff (srst)
    ce && !pdI_ff && pairLast ##1 ce && !pdI_ff |-> busA_ff[0] == $past(g_chan[0].holdA_ff))
    else $error("Bus A did not take the first sample of the pair.");

endmodule

// >>> verif/dapmc_host_model.sv
`timescale 1ns/1ps
module dapmc_host_model (
  // Serial configuration pins as tri-level codes.
  output logic [1:0] sclkCode,
  output logic [1:0] sdataCode,
  output logic [1:0] selCode
);
  // Clock rests low and select rests inactive outside frames.
  initial begin
    sclkCode  = 2'h0;
    sdataCode = 2'h0;
    selCode   = 2'h1;
  end
  // One frame, MSB first, 80 ns per bit; offset keeps edges off the sampling clock.
  task automatic send(input logic [15:0] frame);
    #3 selCode = 2'h0;
    for (int i = 15; i >= 0; i--) begin
      sdataCode = {1'h0, frame[i]};
      #40 sclkCode = 2'h1;
      #40 sclkCode = 2'h0;
    end
    sdataCode = {1'h0, ~frame[0]}; // Stale data would hide a late sample.
    #40 selCode = 2'h1;
  endtask
  // Select level between frames, applied nonblocking in the current time step.
  task automatic setSel(input logic [1:0] code);
    selCode <= code;
  endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 1'h0, srst = 1'h1, ce = 1'h1, calRequestPin = 1'h1;
  logic fullPowerDownPin = 1'h0, secondChannelPowerDownPin = 1'h0, outputClockSyncPulsePin = 1'h0;
  logic [1:0] rangeSelectExtendedEnable = 2'h0, ampLvl = 2'h1, edgeLvl = 2'h1;
  wire [1:0] amplitudeSelectSerialClock, edgeSelectSerialData, calDelayChipSelect;
  wire [1:0] sclkCode, sdataCode;
  logic [7:0] coreSampleI = 8'h00, coreSampleQ = 8'h7F;
  logic [1:0][7:0] busA, busB;
  logic outputDataClock, calStart, powerDownI, powerDownQ, rangeHigh, ampNormal, calDelayLong;
  dapmc_pkg::dapmc_mode_s modeOut;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] rd;
  int fails = 0, checkCount = 0, calCount = 0;
  wire extMode = (rangeSelectExtendedEnable == 2'h2);
  // Serial lines replace the amplitude and edge levels only in extended mode.
  assign amplitudeSelectSerialClock = extMode ? sclkCode : ampLvl;
  assign edgeSelectSerialData = extMode ? sdataCode : edgeLvl;
  always #5 clock = ~clock;
  always @(posedge clock) if (calStart) calCount++;
  dapmc_host_model u_host (.sclkCode, .sdataCode, .selCode(calDelayChipSelect));
  dapmc_control #(.CAL_CYCLES(4)) u_dut (.clock, .srst, .ce, .calRequestPin, .fullPowerDownPin,
    .secondChannelPowerDownPin, .outputClockSyncPulsePin, .rangeSelectExtendedEnable,
    .amplitudeSelectSerialClock, .edgeSelectSerialData, .calDelayChipSelect, .coreSampleI,
    .coreSampleQ, .busA, .busB, .outputDataClock, .calStart, .powerDownI, .powerDownQ,
    .rangeHigh, .ampNormal, .calDelayLong, .modeOut, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Write: both channels offered at once, each released when taken.
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    r = s_axi_bresp;
    if (n >= 50) fails++;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 50) fails++;
  endtask
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog sized well above the whole sequence.
  initial begin
    #200000;
    fails++;
    print_verdict;
  end
  initial begin
    wt(6);
    srst <= 1'h0;
    axr(dapmc_pkg::OFS_CONFIG, rd, resp);
    chk(rd, 32'h2);
    axr(4'hC, rd, resp);
    chk(rd, 32'h0);
    chk(32'(resp), 32'(dapmc_pkg::RESP_SLVERR));
    axw(dapmc_pkg::OFS_STATUS, 32'h1, resp);
    chk(32'(resp), 32'(dapmc_pkg::RESP_SLVERR));
    rangeSelectExtendedEnable <= 2'h1;
    ampLvl <= 2'h0;
    edgeLvl <= 2'h2;
    wt(6);
    chk({rangeHigh, ampNormal, modeOut.ddr, calDelayLong}, 4'hB);
    rangeSelectExtendedEnable <= 2'h0;
    ampLvl <= 2'h1;
    edgeLvl <= 2'h1;
    wt(6);
    chk({rangeHigh, ampNormal, modeOut.edgeRise, modeOut.extended}, 4'h6);
    wt(10);
    chk({busB[1], busB[0]}, 16'hFF80);
    chk({busA[1], busA[0]}, 16'hFF80);
    // Two sync pulses an odd number of cycles apart: a free-running clock fails one.
    repeat (2) begin
      outputClockSyncPulsePin <= 1'h1;
      wt(4);
      chk(outputDataClock, 32'h0);
      wt(1);
      chk(outputDataClock, 32'h1);
      outputClockSyncPulsePin <= 1'h0;
      wt(4);
    end
    fullPowerDownPin <= 1'h1;
    wt(6);
    chk({powerDownI, powerDownQ, busB[1], busB[0]}, 18'h30000);
    fullPowerDownPin <= 1'h0;
    secondChannelPowerDownPin <= 1'h1;
    wt(6);
    chk({powerDownI, powerDownQ, busB[1], busB[0]}, 18'h10080);
    secondChannelPowerDownPin <= 1'h0;
    u_host.setSel(2'h2);
    wt(8);
    chk({modeOut.interleave, busB[1], busB[0]}, 17'h18080);
    u_host.setSel(2'h1);
    calRequestPin <= 1'h0;
    wt(10);
    calRequestPin <= 1'h1;
    wt(20);
    chk(calCount, 1);
    calRequestPin <= 1'h0;
    wt(2);
    calRequestPin <= 1'h1;
    wt(20);
    chk(calCount, 1);
    rangeSelectExtendedEnable <= 2'h2;
    wt(6);
    chk({modeOut.extended, calDelayLong}, 2'h2);
    u_host.send(16'hA5C3);
    wt(6);
    axr(dapmc_pkg::OFS_SERIAL, rd, resp);
    chk(rd, 32'hA5C3);
    axr(dapmc_pkg::OFS_CONFIG, rd, resp);
    chk(rd, 32'h3);
    chk({rangeHigh, ampNormal}, 2'h3);
    print_verdict;
  end
endmodule
